// ==== verilog/spp_paging.sv ====
// Special register paging with a three-entry page stack, plus pointer bytes.
// Assumes the core gives one-cycle pulses for interrupt entry and return,
// and a direct register port with read and write strobes on sys_clk.
//
// Notes on behaviour
// - Direct addresses 0x80-0xFF decode together with an 8-bit page number.
// - Only pages 0x00 and 0x0F hold paged registers.
// - With auto paging on, interrupt entry loads the source's flag page.
// - Stack is current page on top, middle next, bottom last.
// - Entry shifts middle to bottom and current to middle, then loads.
// - Interrupt return moves middle into current page.
// - Return moves bottom into middle; bottom becomes 0x00 when emptied.
// - Rewritten middle and bottom values are restored on return.
// - Software writes to stack entries never push or pop.
// - Push only on interrupt entry, pop only on interrupt return.
// - Auto paging enable bit lives in page control, set at reset.
// - Auto paging disabled means no page switch, push or pop.
// - Some registers answer on every page regardless of current page.
// - Current page writes are accepted unless a push or pop falls in the same cycle, and steer later accesses.
// - All three stack entries are readable and writable.
// - Pointer low byte forms bits 7:0 of the 16-bit data pointer.
// - Pointer high byte forms bits 15:8 of the 16-bit data pointer.
// - Stack pointer resets to 0x07.
// - Pointer bytes and stack pointer sit at 0x82, 0x83, 0x81 on every page.
// - Current page register at 0xA7, every page, resets to zero.
`timescale 1ns/1ps
module spp_paging
   import spp_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  sfr_addr,
   input  wire logic        sfr_wr,
   input  wire logic        sfr_rd,
   input  wire logic [7:0]  sfr_wdata,
   output logic      [7:0]  sfr_rdata,
   output logic             sfr_hit,
   input  wire logic        irq_enter,
   input  wire logic [7:0]  irq_page,
   input  wire logic        irq_return,
   input  wire logic        sp_inc,
   input  wire logic        sp_dec,
   output logic      [7:0]  stack_pointer,
   output logic      [15:0] data_pointer_16,
   output logic      [7:0]  current_page_reg,
   output logic             page_0_sel,
   output logic             page_f_sel,
   output logic             auto_page_enable
);
   import spp_pkg::*;

   // ==========================================================================
   // Address decode
   logic [7:0] page_stack_middle;
   logic [7:0] page_stack_bottom;
   logic [7:0] cur_q;
   logic       pgen_q;
   logic [7:0] sp_q;
   logic [7:0] dpl_w;
   logic [7:0] dph_w;

   // Global registers ignore the page, so they win the decode first.
   wire in_sfr   = (sfr_addr >= SPP_SFR_LO);
   wire hit_sp   = (sfr_addr == SPP_ADDR_SP);
   wire hit_dpl  = (sfr_addr == SPP_ADDR_DPL);
   wire hit_dph  = (sfr_addr == SPP_ADDR_DPH);
   wire hit_page = (sfr_addr == SPP_ADDR_PAGE);
   wire hit_next = (sfr_addr == SPP_ADDR_NEXT);
   wire hit_last = (sfr_addr == SPP_ADDR_LAST);
   wire hit_pgcn = (sfr_addr == SPP_ADDR_PGCN);
   wire hit_glob = hit_sp | hit_dpl | hit_dph | hit_page | hit_next
                 | hit_last | hit_pgcn;

   // ==========================================================================
   // Stack sequencing
   // Entry and return act only while auto paging is on.
   wire do_push  = irq_enter  & pgen_q;
   wire do_pop   = irq_return & pgen_q & ~irq_enter;
   spp_op_e op;
   assign op = do_push ? SPP_PUSH : (do_pop ? SPP_POP : SPP_IDLE);

   wire wr_sp    = sfr_wr & hit_sp;
   wire wr_dpl   = sfr_wr & hit_dpl;
   wire wr_dph   = sfr_wr & hit_dph;
   wire wr_page  = sfr_wr & hit_page;
   wire wr_next  = sfr_wr & hit_next;
   wire wr_last  = sfr_wr & hit_last;
   wire wr_pgcn  = sfr_wr & hit_pgcn;

   logic [7:0] cur_d;
   logic [7:0] mid_d;
   logic [7:0] bot_d;
   logic       mid_ld;
   logic       bot_ld;

   // Next stack contents; a push or pop overrides a same-cycle write.
   always_comb
   begin
      cur_d  = cur_q;
      mid_d  = page_stack_middle;
      bot_d  = page_stack_bottom;
      mid_ld = 1'b0;
      bot_ld = 1'b0;
      case (op)
         SPP_PUSH:
         begin
            bot_d  = page_stack_middle;
            mid_d  = cur_q;
            cur_d  = irq_page;
            mid_ld = 1'b1;
            bot_ld = 1'b1;
         end
         SPP_POP:
         begin
            cur_d  = page_stack_middle;
            mid_d  = page_stack_bottom;
            bot_d  = SPP_EMPTY_PAGE;
            mid_ld = 1'b1;
            bot_ld = 1'b1;
         end
         default:
         begin
            // Plain writes only touch their own entry.
            if (wr_page)
               cur_d = sfr_wdata;
            if (wr_next)
            begin
               mid_d  = sfr_wdata;
               mid_ld = 1'b1;
            end
            if (wr_last)
            begin
               bot_d  = sfr_wdata;
               bot_ld = 1'b1;
            end
         end
      endcase
   end

   // ==========================================================================
   // Registers
   // Middle and bottom share one storage cell type.
   spp_byte_reg #(.RST_VAL(SPP_RST_BYTE)) u_mid
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .load    (mid_ld),
      .din     (mid_d),
      .dout    (page_stack_middle)
   );
   spp_byte_reg #(.RST_VAL(SPP_RST_BYTE)) u_bot
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .load    (bot_ld),
      .din     (bot_d),
      .dout    (page_stack_bottom)
   );
   spp_byte_reg #(.RST_VAL(SPP_RST_BYTE)) u_dpl
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .load    (wr_dpl),
      .din     (sfr_wdata),
      .dout    (dpl_w)
   );
   spp_byte_reg #(.RST_VAL(SPP_RST_BYTE)) u_dph
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .load    (wr_dph),
      .din     (sfr_wdata),
      .dout    (dph_w)
   );

   // Stack pointer pre-increments for a push; a software write wins.
   wire [7:0] sp_d = wr_sp  ? sfr_wdata
                   : sp_inc ? 8'(sp_q + 8'h01)
                   : sp_dec ? 8'(sp_q - 8'h01)
                   : sp_q;

   // Top of stack, enable and stack pointer.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         cur_q  <= SPP_RST_BYTE;
         pgen_q <= SPP_RST_PGEN;
         sp_q   <= SPP_RST_SP;
      end
      else
      begin
         cur_q  <= cur_d;
         sp_q   <= sp_d;
         if (wr_pgcn)
            pgen_q <= sfr_wdata[SPP_PGEN_BIT];
      end
   end

   // ==========================================================================
   // Read mux
   // Unmapped or unpopulated addresses read zero and report no hit.
   wire [7:0] rd_mux = hit_sp   ? sp_q
                     : hit_dpl  ? dpl_w
                     : hit_dph  ? dph_w
                     : hit_page ? cur_q
                     : hit_next ? page_stack_middle
                     : hit_last ? page_stack_bottom
                     : hit_pgcn ? {7'h00, pgen_q}
                     : 8'h00;

   // Registered outputs, one cycle after the strobe.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         sfr_rdata        <= 8'h00;
         sfr_hit          <= 1'b0;
         stack_pointer    <= SPP_RST_SP;
         data_pointer_16  <= 16'h0000;
         current_page_reg <= SPP_RST_BYTE;
         page_0_sel       <= 1'b1;
         page_f_sel       <= 1'b0;
         auto_page_enable <= SPP_RST_PGEN;
      end
      else
      begin
         sfr_rdata        <= sfr_rd ? rd_mux : 8'h00;
         sfr_hit          <= (sfr_rd | sfr_wr) & in_sfr & hit_glob;
         stack_pointer    <= sp_d;
         data_pointer_16  <= {(wr_dph ? sfr_wdata : dph_w),
                               (wr_dpl ? sfr_wdata : dpl_w)};
         current_page_reg <= cur_d;
         page_0_sel       <= (cur_d == SPP_PAGE_0);
         page_f_sel       <= (cur_d == SPP_PAGE_F);
         auto_page_enable <= wr_pgcn ? sfr_wdata[SPP_PGEN_BIT] : pgen_q;
      end
   end

   // ==========================================================================
   // Checks
   property p_push;
      @(posedge sys_clk) disable iff (!rst_n)
      (irq_enter && pgen_q) |=> (cur_q == $past(irq_page))
         && (page_stack_middle == $past(cur_q))
         && (page_stack_bottom == $past(page_stack_middle));
   endproperty
   a_push: assert property (p_push) else $error("push wrong");

   property p_pop;
      @(posedge sys_clk) disable iff (!rst_n)
      (irq_return && !irq_enter && pgen_q) |=> (cur_q == $past(page_stack_middle))
         && (page_stack_middle == $past(page_stack_bottom))
         && (page_stack_bottom == SPP_EMPTY_PAGE);
   endproperty
   a_pop: assert property (p_pop) else $error("pop wrong");

   property p_off;
      @(posedge sys_clk) disable iff (!rst_n)
      (!pgen_q && (irq_enter || irq_return) && !sfr_wr) |=> $stable(cur_q)
         && $stable(page_stack_middle) && $stable(page_stack_bottom);
   endproperty
   a_off: assert property (p_off) else $error("stack moved while off");

   property p_wr_next;
      @(posedge sys_clk) disable iff (!rst_n)
      (wr_next && !irq_enter && !irq_return) |=> (page_stack_middle == $past(sfr_wdata))
         && $stable(cur_q) && $stable(page_stack_bottom);
   endproperty
   a_wr_next: assert property (p_wr_next) else $error("next write");

   property p_wr_page;
      @(posedge sys_clk) disable iff (!rst_n)
      (wr_page && !irq_enter && !irq_return) |=> (current_page_reg == $past(sfr_wdata));
   endproperty
   a_wr_page: assert property (p_wr_page) else $error("page write");

   property p_prio;
      @(posedge sys_clk) disable iff (!rst_n)
      ((wr_last || wr_next) && irq_enter && pgen_q) |=>
         (page_stack_bottom == $past(page_stack_middle))
         && (page_stack_middle == $past(cur_q));
   endproperty
   a_prio: assert property (p_prio) else $error("write beat push");

   property p_sp_inc;
      @(posedge sys_clk) disable iff (!rst_n)
      (sp_inc && !wr_sp) |=> (sp_q == 8'($past(sp_q) + 8'h01));
   endproperty
   a_sp_inc: assert property (p_sp_inc) else $error("sp inc");

   property p_data_pointer_16;
      @(posedge sys_clk) disable iff (!rst_n)
      wr_dpl |=> (data_pointer_16[7:0] == $past(sfr_wdata)) ##1
         (data_pointer_16[7:0] == dpl_w);
   endproperty
   a_data_pointer_16: assert property (p_data_pointer_16) else $error("pointer low");

   property p_rd_sp;
      @(posedge sys_clk) disable iff (!rst_n)
      (sfr_rd && hit_sp) |=> (sfr_rdata == $past(sp_q)) && sfr_hit;
   endproperty
   a_rd_sp: assert property (p_rd_sp) else $error("sp read");

   c_push: cover property (@(posedge sys_clk) disable iff (!rst_n) do_push ##[1:20] do_pop);
   c_nest: cover property (@(posedge sys_clk) disable iff (!rst_n) do_push ##[1:9] do_push);
   c_off:  cover property (@(posedge sys_clk) disable iff (!rst_n) !pgen_q && irq_enter);
endmodule : spp_paging

// ==== verilog/spp_pkg.sv ====
// Constants for the special register paging and pointer block.
// Assumes a single core clock and an 8-bit direct register port from the core.
package spp_pkg;
   // ==========================================================================
   // Addresses
   localparam logic [7:0] SPP_SFR_LO      = 8'h80;
   localparam logic [7:0] SPP_SFR_HI      = 8'hFF;
   localparam logic [7:0] SPP_ADDR_SP     = 8'h81;
   localparam logic [7:0] SPP_ADDR_DPL    = 8'h82;
   localparam logic [7:0] SPP_ADDR_DPH    = 8'h83;
   localparam logic [7:0] SPP_ADDR_PAGE   = 8'hA7;
   localparam logic [7:0] SPP_ADDR_NEXT   = 8'hA8;
   localparam logic [7:0] SPP_ADDR_LAST   = 8'hA9;
   localparam logic [7:0] SPP_ADDR_PGCN   = 8'hAA;
   // Pages that hold registers.
   localparam logic [7:0] SPP_PAGE_0      = 8'h00;
   localparam logic [7:0] SPP_PAGE_F      = 8'h0F;
   // ==========================================================================
   // Fields and reset values
   localparam int         SPP_PGEN_BIT    = 0;
   localparam logic [7:0] SPP_RST_SP      = 8'h07;
   localparam logic [7:0] SPP_RST_BYTE    = 8'h00;
   localparam logic       SPP_RST_PGEN    = 1'b1;
   localparam logic [7:0] SPP_EMPTY_PAGE  = 8'h00;
   // ==========================================================================
   // Sequencer states of the stack
   typedef enum logic [2:0]
   {
      SPP_IDLE = 3'b001,
      SPP_PUSH = 3'b010,
      SPP_POP  = 3'b100
   } spp_op_e;
endpackage : spp_pkg

// ==== verilog/spp_byte_reg.sv ====
// One 8-bit register with load enable and synchronous reset value.
// Assumes rst_n is synchronous to sys_clk.
`timescale 1ns/1ps
module spp_byte_reg #(
   parameter logic [7:0] RST_VAL = 8'h00
)(
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic       load,
   input  wire logic [7:0] din,
   output logic      [7:0] dout
);
   // ==========================================================================
   // Storage
   // Holds its value unless loaded.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         dout <= RST_VAL;
      else if (load)
         dout <= din;
   end
endmodule : spp_byte_reg

// ==== bench/spp_core_model.sv ====
// Behavioural stand-in for the core's interrupt and stack sequencing.
// Assumes the bench calls its tasks at a falling edge of sys_clk.
`timescale 1ns/1ps
module spp_core_model (
   input  wire logic       sys_clk,
   output logic            irq_enter,
   output logic      [7:0] irq_page,
   output logic            irq_return,
   output logic            sp_inc,
   output logic            sp_dec
);
   // ==========================================================================
   // Idle levels
   // The page bus is not held between entries, so a stale value cannot pass.
   initial
   begin
      irq_enter  = 1'b0;
      irq_page   = 8'hA5;
      irq_return = 1'b0;
      sp_inc     = 1'b0;
      sp_dec     = 1'b0;
   end

   // ==========================================================================
   // Interrupt entry with the flag page of the serviced source.
   task automatic enter(input logic [7:0] pg);
      irq_enter = 1'b1;
      irq_page  = pg;
      @(negedge sys_clk);
      irq_enter = 1'b0;
      irq_page  = ~pg;
      @(negedge sys_clk);
   endtask : enter

   // Return from interrupt, the only source of a pop.
   task automatic leave();
      irq_return = 1'b1;
      @(negedge sys_clk);
      irq_return = 1'b0;
      @(negedge sys_clk);
   endtask : leave

   // One stack pointer step, up or down.
   task automatic step(input logic up);
      sp_inc = up;
      sp_dec = ~up;
      @(negedge sys_clk);
      sp_inc = 1'b0;
      sp_dec = 1'b0;
      @(negedge sys_clk);
   endtask : step
endmodule : spp_core_model

// ==== bench/spp_paging_tb.sv ====
// Self-checking bench for the paging block, register port and page stack.
// Assumes spp_pkg is compiled first and the core model drives the interrupt side.
`timescale 1ns/1ps
module spp_paging_tb;
   import spp_pkg::*;
   logic        sys_clk, rst_n, sfr_wr, sfr_rd, sfr_hit;
   logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, irq_page, stack_pointer, current_page_reg;
   logic        irq_enter, irq_return, sp_inc, sp_dec;
   logic        page_0_sel, page_f_sel, auto_page_enable;
   logic [15:0] data_pointer_16;
   logic [7:0]  v;
   int          n_errors, comparisons;

   spp_paging i_spp_paging (.sys_clk(sys_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .sfr_hit(sfr_hit), .irq_enter(irq_enter), .irq_page(irq_page),
      .irq_return(irq_return), .sp_inc(sp_inc), .sp_dec(sp_dec),
      .stack_pointer(stack_pointer), .data_pointer_16(data_pointer_16),
      .current_page_reg(current_page_reg), .page_0_sel(page_0_sel),
      .page_f_sel(page_f_sel), .auto_page_enable(auto_page_enable));

   spp_core_model i_spp_core_model (.sys_clk(sys_clk), .irq_enter(irq_enter),
      .irq_page(irq_page), .irq_return(irq_return), .sp_inc(sp_inc), .sp_dec(sp_dec));

   // ==========================================================================
   // Clock, 25 ns period.
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // ==========================================================================
   // Compare, register access and closing tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Every access spans two cycles so a strobe never rises again in the same step.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr  = a;
      sfr_wdata = d;
      sfr_wr    = 1'b1;
      @(negedge sys_clk);
      sfr_wr    = 1'b0;
      sfr_wdata = ~d;
      @(negedge sys_clk);
   endtask : wr

   // Read data stands one cycle only, so it is sampled at the first falling edge.
   task automatic rd(input logic [7:0] a, input logic h, output logic [7:0] d);
      sfr_addr = a;
      sfr_rd   = 1'b1;
      @(negedge sys_clk);
      sfr_rd   = 1'b0;
      d        = sfr_rdata;
      chk({15'h0000, sfr_hit}, {15'h0000, h});
      @(negedge sys_clk);
   endtask : rd

   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      rd(a, 1'b1, v);
      chk({8'h00, v}, {8'h00, e});
   endtask : rdc

   task automatic results();
      $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results

   // ==========================================================================
   // Watchdog, far beyond the roughly 110 cycles the tests need.
   initial
   begin
      #100000;
      n_errors++;
      results();
   end

   // ==========================================================================
   // Test sequence
   initial
   begin
      n_errors = 0;
      comparisons = 0;
      rst_n = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      rst_n = 1'b1;
      // Reset values of every global register.
      rdc(SPP_ADDR_SP, 8'h07);
      rdc(SPP_ADDR_DPL, 8'h00);
      rdc(SPP_ADDR_DPH, 8'h00);
      rdc(SPP_ADDR_PAGE, 8'h00);
      rdc(SPP_ADDR_NEXT, 8'h00);
      rdc(SPP_ADDR_LAST, 8'h00);
      rd(SPP_ADDR_PGCN, 1'b1, v);
      chk({15'h0000, v[SPP_PGEN_BIT]}, 16'h0001);
      chk({15'h0000, auto_page_enable}, 16'h0001);
      $display("test reset done");
      // Pointer bytes seen from both pages, and an unmapped place.
      wr(SPP_ADDR_PAGE, 8'h0F);
      chk({14'h0000, page_f_sel, page_0_sel}, 16'h0002);
      wr(SPP_ADDR_DPL, 8'h34);
      wr(SPP_ADDR_DPH, 8'h12);
      chk(data_pointer_16, 16'h1234);
      rdc(SPP_ADDR_DPL, 8'h34);
      wr(SPP_ADDR_PAGE, 8'h00);
      chk({14'h0000, page_f_sel, page_0_sel}, 16'h0001);
      rdc(SPP_ADDR_DPH, 8'h12);
      rdc(SPP_ADDR_SP, 8'h07);
      rd(8'h90, 1'b0, v);
      chk({8'h00, v}, 16'h0000);
      $display("test pointers done");
      // Stack pointer steps.
      i_spp_core_model.step(1'b1);
      chk({8'h00, stack_pointer}, 16'h0008);
      i_spp_core_model.step(1'b0);
      rdc(SPP_ADDR_SP, 8'h07);
      $display("test stack pointer done");
      // Nested entries and returns with software-written stack entries.
      wr(SPP_ADDR_PAGE, 8'h0F);
      wr(SPP_ADDR_NEXT, 8'h33);
      wr(SPP_ADDR_LAST, 8'h55);
      rdc(SPP_ADDR_PAGE, 8'h0F);
      rdc(SPP_ADDR_NEXT, 8'h33);
      i_spp_core_model.enter(8'h00);
      chk({8'h00, current_page_reg}, 16'h0000);
      rdc(SPP_ADDR_NEXT, 8'h0F);
      rdc(SPP_ADDR_LAST, 8'h33);
      i_spp_core_model.enter(8'h0F);
      rdc(SPP_ADDR_PAGE, 8'h0F);
      rdc(SPP_ADDR_NEXT, 8'h00);
      rdc(SPP_ADDR_LAST, 8'h0F);
      i_spp_core_model.leave();
      rdc(SPP_ADDR_PAGE, 8'h00);
      rdc(SPP_ADDR_NEXT, 8'h0F);
      rdc(SPP_ADDR_LAST, 8'h00);
      wr(SPP_ADDR_NEXT, 8'h22);
      rdc(SPP_ADDR_PAGE, 8'h00);
      i_spp_core_model.leave();
      rdc(SPP_ADDR_PAGE, 8'h22);
      rdc(SPP_ADDR_NEXT, 8'h00);
      $display("test page stack done");
      // Auto paging switched off: entry and return leave the stack alone.
      wr(SPP_ADDR_PGCN, 8'h00);
      i_spp_core_model.enter(8'h0F);
      rdc(SPP_ADDR_PAGE, 8'h22);
      rdc(SPP_ADDR_NEXT, 8'h00);
      i_spp_core_model.leave();
      rdc(SPP_ADDR_PAGE, 8'h22);
      wr(SPP_ADDR_PGCN, 8'h01);
      $display("test auto paging off done");
      // A stack write in the very cycle of an entry loses to the push.
      fork
         i_spp_core_model.enter(8'h0F);
         wr(SPP_ADDR_NEXT, 8'h77);
      join
      rdc(SPP_ADDR_NEXT, 8'h22);
      rdc(SPP_ADDR_PAGE, 8'h0F);
      $display("test collision done");
      // Stack pointer write, then a reset in mid-run restores every register.
      wr(SPP_ADDR_SP, 8'h30);
      chk({8'h00, stack_pointer}, 16'h0030);
      wr(SPP_ADDR_PGCN, 8'h00);
      rst_n = 1'b0;
      @(negedge sys_clk);
      rst_n = 1'b1;
      chk({8'h00, current_page_reg}, 16'h0000);
      chk({14'h0000, page_f_sel, page_0_sel}, 16'h0001);
      chk(data_pointer_16, 16'h0000);
      chk({15'h0000, auto_page_enable}, 16'h0001);
      rdc(SPP_ADDR_SP, 8'h07);
      rdc(SPP_ADDR_NEXT, 8'h00);
      rdc(SPP_ADDR_LAST, 8'h00);
      $display("test mid-run reset done");
      results();
   end
endmodule : spp_paging_tb
